/* include/pccs_pkg.sv */
//
// Purpose: shared constants and types for the pci cache command selector
// Assumes: pci clock domain, 32-bit bus, byte counts in bytes
// Notes: register offsets are local to the plain register port
//
`default_nettype none
package pccs_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [3:0] OFS_CLS = 4'h0; // cache_line_size_reg
	localparam logic [3:0] OFS_CTRL = 4'h1; // transfer_control_reg
	localparam logic [3:0] OFS_MODE = 4'h2; // transfer_mode_reg
	localparam logic [3:0] OFS_T3 = 4'h3; // test_reg_three
	localparam logic [3:0] OFS_T5 = 4'h4; // test_reg_five
	localparam logic [3:0] OFS_PCICMD = 4'h5; // pci command register
	localparam logic [3:0] OFS_STAT = 4'h6; // selector status
	// field positions
	localparam int CTRL_CSE_BIT = 7; // cache_size_enable
	localparam int MODE_BL_HI = 7;
	localparam int MODE_BL_LO = 6;
	localparam int MODE_RL_BIT = 3; // read_line_enable
	localparam int MODE_RM_BIT = 2; // read_multiple_enable
	localparam int T3_WI_BIT = 0; // chip_write_invalidate_enable
	localparam int T5_BL_BIT = 2;
	localparam int PCICMD_WI_BIT = 4; // pci_write_invalidate_enable
	localparam logic [7:0] RST_BYTE = 8'h00;
	// ------------------------------------------------------------
	// pci commands
	// ------------------------------------------------------------
	typedef enum logic [3:0]
	{
		CMD_MR = 4'h6,
		CMD_MW = 4'h7,
		CMD_MRM = 4'hc,
		CMD_MRL = 4'he,
		CMD_MWI = 4'hf
	} pccs_cmd_t;
	// transfer kinds from the requesting engine
	typedef enum logic [1:0]
	{
		KIND_NORMAL = 2'b00,
		KIND_NOPF_FETCH = 2'b01,
		KIND_LOADSTORE = 2'b10,
		KIND_FLUSH = 2'b11
	} pccs_kind_t;
	// request from the dma engine
	typedef struct packed
	{
		logic [31:0] addr;
		logic [31:0] src_addr;
		logic [15:0] count;
		logic write;
		logic mem2mem;
		pccs_kind_t kind;
	} pccs_req_t;
	// one burst decision
	typedef struct packed
	{
		pccs_cmd_t cmd;
		logic [31:0] addr;
		logic [15:0] bytes;
	} pccs_burst_t;
	localparam logic [15:0] DW_BYTES = 16'h0004;
	localparam logic [1:0] DW_MASK = 2'h3;
endpackage : pccs_pkg
`default_nettype wire

/* design/pccs_select.sv */
//
// Purpose: choose pci command and burst split for bus-master transfers
// Assumes: one request in flight; bus side acknowledges each burst
// Notes: register port is plain address/strobe; read data next cycle
//
// Functional notes
// - eight-bit cache line size register detects misalignment
// - cache commands only with cache size enable
// - only 4..128 power-of-two dwords valid
// - burst length must reach cache line size
// - no cache for fetch, load/store, flush
// - failed preconditions: plain read/write, no alignment
// - read line needs read line enable
// - read multiple needs read multiple enable
// - invalidate needs both write invalidate enables
// - disabled command falls back to next enabled
// - no commands enabled: still align writes
// - reads unaligned, burst length sized
// - short read fetched in one burst
// - dword crossing read uses read line
// - cache line crossing read uses read multiple
// - otherwise plain memory read
// - first write burst reaches line boundary
// - invalidate bursts while remaining exceeds threshold
// - residual plain write finishes transfer
// - memory moves need matching low address bits
// - little endian, byte zero on bits 7:0
// - read multiple wins over read line on cache line crossing
// - invalidate needs full line buffered, aligned
// - latency expiry in invalidate: finish line, then release
// - after disconnect, invalidate only if aligned
//
`default_nettype none
module pccs_select
	import pccs_pkg::*;
(
	input wire logic CORE_CLK, // pci clock
	input wire logic RST, // synchronous reset, high
	input wire logic [3:0] REG_ADDR, // register index
	input wire logic [7:0] REG_WDATA, // register write data
	input wire logic REG_WR, // write strobe
	input wire logic REG_RD, // read strobe
	output logic [7:0] REG_RDATA, // read data, cycle after strobe
	input wire pccs_req_t REQ, // transfer request
	input wire logic REQ_VALID, // request strobe
	output logic REQ_READY, // idle, can take request
	input wire logic [15:0] BUF_BYTES, // bytes held in transfer buffer
	output pccs_burst_t BURST, // current burst decision
	output logic BURST_VALID, // burst decision valid
	input wire logic BURST_DONE, // bus finished burst
	input wire logic [15:0] DONE_BYTES, // bytes moved by that burst
	input wire logic LAT_EXPIRE, // latency timer expired
	input wire logic DISCONNECT, // target ended burst early
	output logic BUS_RELEASE, // give up bus at line boundary
	output logic XFER_DONE // one-cycle end of transfer
);
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0] cls_q, ctrl_q, mode_q, t3_q, t5_q, pcicmd_q;
	logic [7:0] rdata_q;
	// register writes
	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			cls_q <= RST_BYTE;
			ctrl_q <= RST_BYTE;
			mode_q <= RST_BYTE;
			t3_q <= RST_BYTE;
			t5_q <= RST_BYTE;
			pcicmd_q <= RST_BYTE;
		end
		else if (REG_WR)
		begin
			if (REG_ADDR == OFS_CLS) cls_q <= REG_WDATA;
			if (REG_ADDR == OFS_CTRL) ctrl_q <= REG_WDATA;
			if (REG_ADDR == OFS_MODE) mode_q <= REG_WDATA;
			if (REG_ADDR == OFS_T3) t3_q <= REG_WDATA;
			if (REG_ADDR == OFS_T5) t5_q <= REG_WDATA;
			if (REG_ADDR == OFS_PCICMD) pcicmd_q <= REG_WDATA;
		end
	end
	// ------------------------------------------------------------
	// cache mode qualification
	// ------------------------------------------------------------
	wire cls_valid = (cls_q == 8'h04) || (cls_q == 8'h08) ||
		(cls_q == 8'h10) || (cls_q == 8'h20) || (cls_q == 8'h40) ||
		(cls_q == 8'h80);
	// burst length code: mode[7:6] plus test five bit 2
	wire [2:0] bl_code = {t5_q[T5_BL_BIT], mode_q[MODE_BL_HI:MODE_BL_LO]};
	// burst length in dwords = 2 << code
	wire [8:0] bl_dw = 9'h002 << bl_code;
	wire [15:0] bl_bytes = {5'h00, bl_dw, 2'b00};
	wire [15:0] cls_bytes = {6'h00, cls_q, 2'b00};
	wire cache_base = ctrl_q[CTRL_CSE_BIT] && cls_valid &&
		({1'b0, cls_q} <= bl_dw);
	wire rl_en = mode_q[MODE_RL_BIT];
	wire rm_en = mode_q[MODE_RM_BIT];
	wire wi_en = t3_q[T3_WI_BIT] && pcicmd_q[PCICMD_WI_BIT];
	// ------------------------------------------------------------
	// transfer state
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_ISSUE = 2'b01,
		ST_WAIT = 2'b10
	} pccs_state_t;
	pccs_state_t state_q, state_d;
	pccs_req_t req_q;
	logic cache_q; // cache mode for this transfer
	logic [31:0] addr_q;
	logic [15:0] rem_q;
	pccs_burst_t burst_q;
	logic bvalid_q, release_q, done_q;
	// cache mode per transfer
	wire kind_ok = (REQ.kind == KIND_NORMAL);
	wire cache_now = cache_base && kind_ok;
	// alignment quantities
	wire [15:0] cls_mask = cls_bytes - 16'h0001;
	wire [15:0] off_line = addr_q[15:0] & cls_mask;
	wire [15:0] to_line = (off_line == 16'h0000) ? 16'h0000 :
		cls_bytes - off_line;
	wire line_aligned = (off_line == 16'h0000);
	// memory moves need identical low three bits on both ends
	wire m2m_ok = !req_q.mem2mem ||
		(req_q.src_addr[2:0] == req_q.addr[2:0]);
	wire walign = cache_q && m2m_ok;
	// ------------------------------------------------------------
	// read burst sizing and command
	// ------------------------------------------------------------
	wire [15:0] rd_len = (rem_q < bl_bytes) ? rem_q : bl_bytes;
	// short transfer goes in one burst
	wire [15:0] rd_end = addr_q[15:0] + rd_len - 16'h0001;
	wire rd_cross_dw = (rd_end[15:2] != addr_q[15:2]);
	wire rd_cross_cl = ((rd_end & ~cls_mask) !=
		(addr_q[15:0] & ~cls_mask));
	// line crossing prefers read multiple, dword crossing prefers read line
	wire pccs_cmd_t rd_cmd = !cache_q ? CMD_MR :
		(rd_cross_cl && rm_en) ? CMD_MRM :
		(rd_cross_cl && rl_en) ? CMD_MRL :
		(rd_cross_dw && rl_en) ? CMD_MRL :
		(rd_cross_dw && rm_en) ? CMD_MRM : CMD_MR;
	// ------------------------------------------------------------
	// write burst sizing and command
	// ------------------------------------------------------------
	// largest multiple of line size not above remaining or burst length
	wire [15:0] wi_cap = (rem_q < bl_bytes) ? rem_q : bl_bytes;
	wire [15:0] wi_len = wi_cap & ~cls_mask;
	wire wi_ok = walign && wi_en && line_aligned &&
		(wi_len != 16'h0000) && (BUF_BYTES >= cls_bytes);
	wire [15:0] wr_plain = (rem_q < bl_bytes) ? rem_q : bl_bytes;
	wire do_align = walign && !line_aligned && (rem_q > to_line);
	wire [15:0] wr_len = wi_ok ? wi_len :
		do_align ? ((to_line < bl_bytes) ? to_line : bl_bytes) :
		wr_plain;
	wire pccs_cmd_t wr_cmd = wi_ok ? CMD_MWI : CMD_MW;
	// ------------------------------------------------------------
	// state machine
	// ------------------------------------------------------------
	wire [15:0] moved = (DONE_BYTES > rem_q) ? rem_q : DONE_BYTES;
	wire [15:0] rem_next = rem_q - moved;
	wire last = (rem_next == 16'h0000);
	wire mwi_run = bvalid_q && (burst_q.cmd == CMD_MWI);
	// next state
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: if (REQ_VALID) state_d = ST_ISSUE;
			ST_ISSUE: state_d = ST_WAIT;
			ST_WAIT: if (BURST_DONE) state_d = last ? ST_IDLE : ST_ISSUE;
		endcase
	end
	// sequencing registers
	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			state_q <= ST_IDLE;
			req_q <= '0;
			cache_q <= 1'b0;
			addr_q <= 32'h0000_0000;
			rem_q <= 16'h0000;
			burst_q <= '{cmd: CMD_MR, addr: 32'h0000_0000, bytes: 16'h0000};
			bvalid_q <= 1'b0;
			release_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			done_q <= 1'b0;
			if (state_q == ST_IDLE && REQ_VALID)
			begin
				req_q <= REQ;
				cache_q <= cache_now;
				addr_q <= REQ.addr;
				rem_q <= REQ.count;
			end
			if (state_q == ST_ISSUE)
			begin
				// byte lanes stay little endian: lane 0 is bits 7:0
				burst_q.addr <= addr_q;
				burst_q.cmd <= req_q.write ? wr_cmd : rd_cmd;
				burst_q.bytes <= req_q.write ? wr_len : rd_len;
				bvalid_q <= 1'b1;
				release_q <= 1'b0;
			end
			// latency expiry in invalidate: run to line end, then release
			if (mwi_run && LAT_EXPIRE)
				release_q <= 1'b1;
			if (state_q == ST_WAIT && BURST_DONE)
			begin
				addr_q <= addr_q + {16'h0000, moved};
				rem_q <= rem_next;
				bvalid_q <= 1'b0;
				// re-evaluated from new address on next ownership
				done_q <= last;
			end
		end
	end
	// ------------------------------------------------------------
	// register readback
	// ------------------------------------------------------------
	wire [7:0] stat = {4'h0, bvalid_q, cache_q, state_q};
	wire [7:0] rd_mux = (REG_ADDR == OFS_CLS) ? cls_q :
		(REG_ADDR == OFS_CTRL) ? ctrl_q :
		(REG_ADDR == OFS_MODE) ? mode_q :
		(REG_ADDR == OFS_T3) ? t3_q :
		(REG_ADDR == OFS_T5) ? t5_q :
		(REG_ADDR == OFS_PCICMD) ? pcicmd_q :
		(REG_ADDR == OFS_STAT) ? stat : RST_BYTE;
	// read data register, zero outside read cycle
	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
			rdata_q <= RST_BYTE;
		else
			rdata_q <= REG_RD ? rd_mux : RST_BYTE;
	end
	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	logic ready_q;
	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
			ready_q <= 1'b0;
		else
			ready_q <= (state_d == ST_IDLE);
	end
	assign REG_RDATA = rdata_q;
	assign REQ_READY = ready_q;
	assign BURST = burst_q;
	assign BURST_VALID = bvalid_q;
	assign BUS_RELEASE = release_q;
	assign XFER_DONE = done_q;
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_no_cache_cmd: assert property (@(posedge CORE_CLK) disable iff (RST)
		(bvalid_q && !cache_q) |-> (burst_q.cmd inside {CMD_MR, CMD_MW}))
		else $error("cache command without cache mode");
	a_mwi_enable: assert property (@(posedge CORE_CLK) disable iff (RST)
		(bvalid_q && burst_q.cmd == CMD_MWI) |-> wi_en)
		else $error("invalidate issued while disabled");
	a_mwi_aligned: assert property (@(posedge CORE_CLK) disable iff (RST)
		(bvalid_q && burst_q.cmd == CMD_MWI) |->
		((burst_q.addr[15:0] & cls_mask) == 16'h0000))
		else $error("invalidate burst not line aligned");
	a_mrl_enable: assert property (@(posedge CORE_CLK) disable iff (RST)
		(bvalid_q && burst_q.cmd == CMD_MRL) |-> rl_en)
		else $error("read line issued while disabled");
	a_mrm_enable: assert property (@(posedge CORE_CLK) disable iff (RST)
		(bvalid_q && burst_q.cmd == CMD_MRM) |-> rm_en)
		else $error("read multiple issued while disabled");
	a_rd_len_cap: assert property (@(posedge CORE_CLK) disable iff (RST)
		(state_q == ST_ISSUE && !req_q.write) |=>
		(burst_q.bytes <= bl_bytes))
		else $error("read burst above burst length");
	a_kind_bypass: assert property (@(posedge CORE_CLK) disable iff (RST)
		(state_q == ST_IDLE && REQ_VALID && REQ.kind != KIND_NORMAL)
		|=> !cache_q)
		else $error("cache used on excluded transfer");
	a_done_idle: assert property (@(posedge CORE_CLK) disable iff (RST)
		$rose(done_q) |-> (state_q == ST_IDLE && rem_q == 16'h0000))
		else $error("transfer end with bytes left");
	c_mwi: cover property (@(posedge CORE_CLK) bvalid_q && burst_q.cmd == CMD_MWI);
	c_mrm: cover property (@(posedge CORE_CLK) bvalid_q && burst_q.cmd == CMD_MRM);
	c_mrl: cover property (@(posedge CORE_CLK) bvalid_q && burst_q.cmd == CMD_MRL);
	c_release: cover property (@(posedge CORE_CLK) release_q);
endmodule : pccs_select
`default_nettype wire

/* dv/pccs_target.sv */
// Purpose: pci target model that answers selector bursts
// Assumes: one burst on offer at a time, taken whole
// Notes: wait cycles before each burst end come from the bench
`default_nettype none
module pccs_target
	import pccs_pkg::*;
(
	input wire logic clk, // pci clock
	input wire logic rst, // sync reset, high
	input wire pccs_burst_t burst, // burst on offer
	input wire logic burst_valid, // burst offered
	input wire logic [3:0] delay, // wait cycles
	output logic burst_done, // one-cycle end of burst
	output logic [15:0] done_bytes // bytes moved
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] wait_q;
	logic [15:0] bytes_q;
	// count waits, then end the burst for one cycle
	always_ff @(posedge clk)
	begin
		if (rst || burst_done)
		begin
			burst_done <= 1'b0;
			wait_q <= 4'h0;
		end
		else if (burst_valid)
		begin
			bytes_q <= burst.bytes;
			wait_q <= wait_q + 4'h1;
			burst_done <= (wait_q == delay);
		end
	end
	// outside the pulse the count is scrambled so it cannot be trusted
	assign done_bytes = burst_done ? bytes_q : ~bytes_q;
endmodule : pccs_target
`default_nettype wire

/* dv/pccs_select_tb.sv */
// Purpose: self-checking bench for the cache command selector
// Assumes: target model moves every burst in full
// Notes: disconnect held low; latency expiry held low except in the second write run
`default_nettype none
module pccs_select_tb;
	import pccs_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic CORE_CLK, RST, REG_WR, REG_RD, REQ_VALID, REQ_READY;
	logic [3:0] REG_ADDR, delay;
	logic [7:0] REG_WDATA, REG_RDATA;
	pccs_req_t REQ;
	logic [15:0] BUF_BYTES, DONE_BYTES;
	pccs_burst_t BURST;
	logic BURST_VALID, BURST_DONE, BUS_RELEASE, XFER_DONE;
	logic lat_expire, seen_rel;
	logic [19:0] exp_q[$];
	logic [19:0] got_q[$];
	int mismatches, comparisons, cycles;
	pccs_select pccs_select_inst (.CORE_CLK(CORE_CLK), .RST(RST),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
		.REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REQ(REQ),
		.REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
		.BUF_BYTES(BUF_BYTES), .BURST(BURST), .BURST_VALID(BURST_VALID),
		.BURST_DONE(BURST_DONE), .DONE_BYTES(DONE_BYTES),
		.LAT_EXPIRE(lat_expire), .DISCONNECT(1'b0),
		.BUS_RELEASE(BUS_RELEASE),
		.XFER_DONE(XFER_DONE));
	pccs_target pccs_target_inst (.clk(CORE_CLK), .rst(RST), .burst(BURST),
		.burst_valid(BURST_VALID), .delay(delay),
		.burst_done(BURST_DONE), .done_bytes(DONE_BYTES));
	// clock
	initial
	begin
		CORE_CLK = 1'b0;
		forever #20 CORE_CLK = ~CORE_CLK;
	end
	// record finished bursts and cut a hang short
	always @(posedge CORE_CLK)
	begin
		if (BURST_VALID === 1'b1 && BURST_DONE === 1'b1)
			got_q.push_back({BURST.cmd, BURST.bytes});
		if (BUS_RELEASE === 1'b1)
			seen_rel = 1'b1;
		cycles = cycles + 1;
		if (cycles == 20000)
		begin
			mismatches = mismatches + 1;
			complete_run();
		end
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [19:0] seen, input logic [19:0] exp,
		input string what);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic complete_run();
		if (mismatches == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge CORE_CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CORE_CLK);
		REG_WR <= 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge CORE_CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CORE_CLK);
		REG_RD <= 1'b0;
		#1 check({12'h000, REG_RDATA}, {12'h000, exp}, "register");
	endtask : reg_rd
	task automatic setup(input logic [7:0] cache_line_size_reg, ctl, mode, t3, pc);
		reg_wr(OFS_CLS, cache_line_size_reg);
		reg_wr(OFS_CTRL, ctl);
		reg_wr(OFS_MODE, mode);
		reg_wr(OFS_T3, t3);
		reg_wr(OFS_PCICMD, pc);
	endtask : setup
	task automatic e(input pccs_cmd_t c, input logic [15:0] b);
		exp_q.push_back({c, b});
	endtask : e
	// one transfer; partial runs check the listed head and no invalidate
	task automatic go(input logic [31:0] a, input logic [15:0] n,
		input logic w, input pccs_kind_t k, input logic [31:0] s,
		input logic full);
		int i;
		got_q.delete();
		do @(negedge CORE_CLK); while (REQ_READY !== 1'b1);
		@(posedge CORE_CLK);
		REQ <= '{addr: a, src_addr: s, count: n, write: w,
			mem2mem: s != 0, kind: k};
		REQ_VALID <= 1'b1;
		@(posedge CORE_CLK);
		REQ_VALID <= 1'b0;
		do @(negedge CORE_CLK); while (XFER_DONE !== 1'b1);
		if (full)
			check(got_q.size(), exp_q.size(), "burst count");
		for (i = 0; i < exp_q.size(); i++)
			check(i < got_q.size() ? got_q[i] : 'x, exp_q[i], "burst");
		foreach (got_q[j])
			if (!full)
				check(got_q[j][19:16] == CMD_MWI, 0, "invalidate");
		exp_q.delete();
	endtask : go
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		int i;
		for (i = 0; i < 16; i++)
			if (i != 6)
				reg_rd(i[3:0], 8'h00);
		reg_wr(OFS_CLS, 8'ha5);
		reg_rd(OFS_CLS, 8'ha5);
	endtask : t_regs
	task automatic t_reads();
		setup(8'h04, 8'h80, 8'h4c, 8'h00, 8'h00);
		e(CMD_MRL, 16'h0006);
		go(32'h1, 16'h0006, 1'b0, KIND_NORMAL, 0, 1);
		e(CMD_MRM, 16'h0010);
		e(CMD_MR, 16'h0001);
		go(32'h1, 16'h0011, 1'b0, KIND_NORMAL, 0, 1);
		reg_wr(OFS_MODE, 8'h48);
		e(CMD_MRL, 16'h0010);
		e(CMD_MR, 16'h0001);
		go(32'h1, 16'h0011, 1'b0, KIND_NORMAL, 0, 1);
		reg_wr(OFS_MODE, 8'h44);
		e(CMD_MRM, 16'h0006);
		go(32'h1, 16'h0006, 1'b0, KIND_NORMAL, 0, 1);
	endtask : t_reads
	task automatic t_writes();
		setup(8'h04, 8'h80, 8'h4c, 8'h01, 8'h10);
		delay <= 4'h3;
		e(CMD_MW, 16'h000f);
		repeat (4) e(CMD_MWI, 16'h0010);
		e(CMD_MW, 16'h0002);
		go(32'h1, 16'h0051, 1'b1, KIND_NORMAL, 0, 1);
		check({19'h00000, seen_rel}, 20'h00000, "release idle");
		reg_wr(OFS_MODE, 8'h8c);
		lat_expire <= 1'b1;
		e(CMD_MW, 16'h000f);
		repeat (2) e(CMD_MWI, 16'h0020);
		e(CMD_MW, 16'h0002);
		go(32'h1, 16'h0051, 1'b1, KIND_NORMAL, 0, 1);
		lat_expire <= 1'b0;
		check({19'h00000, seen_rel}, 20'h00001, "release");
		delay <= 4'h0;
	endtask : t_writes
	task automatic t_off();
		logic [7:0] cache_line_size_reg[3] = '{8'h04, 8'h06, 8'h08};
		logic [7:0] ctl[3] = '{8'h00, 8'h80, 8'h80};
		int i;
		for (i = 0; i < 3; i++)
		begin
			setup(cache_line_size_reg[i], ctl[i], 8'h4c, 8'h01, 8'h10);
			e(CMD_MR, 16'h0010);
			e(CMD_MR, 16'h0001);
			go(32'h1, 16'h0011, 1'b0, KIND_NORMAL, 0, 1);
			repeat (2) e(CMD_MW, 16'h0010);
			e(CMD_MW, 16'h0001);
			go(32'h1, 16'h0021, 1'b1, KIND_NORMAL, 0, 1);
		end
	endtask : t_off
	task automatic t_misc();
		int k;
		setup(8'h04, 8'h80, 8'h4c, 8'h01, 8'h10);
		for (k = 1; k < 4; k++)
		begin
			e(CMD_MR, 16'h0006);
			go(32'h1, 16'h0006, 1'b0, pccs_kind_t'(k), 0, 1);
		end
		e(CMD_MW, 16'h0010);
		go(32'h1, 16'h0021, 1'b1, KIND_NORMAL, 32'h2, 0);
		e(CMD_MW, 16'h000f);
		e(CMD_MWI, 16'h0010);
		e(CMD_MW, 16'h0002);
		go(32'h1, 16'h0021, 1'b1, KIND_NORMAL, 32'h9, 1);
		BUF_BYTES <= 16'h0008;
		e(CMD_MW, 16'h000f);
		go(32'h1, 16'h0021, 1'b1, KIND_NORMAL, 0, 0);
		BUF_BYTES <= 16'h0100;
		setup(8'h04, 8'h80, 8'h40, 8'h01, 8'h00);
		e(CMD_MR, 16'h0006);
		go(32'h1, 16'h0006, 1'b0, KIND_NORMAL, 0, 1);
		e(CMD_MW, 16'h000f);
		go(32'h1, 16'h0021, 1'b1, KIND_NORMAL, 0, 0);
	endtask : t_misc
	// main sequence
	initial
	begin
		RST = 1'b1;
		REG_ADDR = 4'h0;
		REG_WDATA = 8'h00;
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		REQ = '0;
		REQ_VALID = 1'b0;
		BUF_BYTES = 16'h0100;
		delay = 4'h0;
		lat_expire = 1'b0;
		seen_rel = 1'b0;
		mismatches = 0;
		comparisons = 0;
		cycles = 0;
		repeat (2) @(posedge CORE_CLK);
		RST <= 1'b0;
		t_regs();
		t_reads();
		t_writes();
		t_off();
		t_misc();
		complete_run();
	end
endmodule : pccs_select_tb
`default_nettype wire
